// *** slte_err.sv ***
`timescale 1ns/100ps
`default_nettype none
module slte_err (
	input wire logic clk,
	input wire logic nrst,
	input wire slte_pkg::slte_prim_t rx_prim,
	input wire logic rx_code_err,
	input wire logic rx_crc_ok,
	input wire logic [7:0] rx_type,
	input wire logic rx_fifo_full,
	input wire logic pio_active,
	input wire logic pio_cnt_zero,
	input wire logic tx_start,
	input wire logic [7:0] tx_type,
	input wire logic tx_last,
	input wire logic tx_underrun,
	input wire logic [3:0] retry_limit,
	input wire logic err_clr,
	output slte_pkg::slte_prim_t tx_prim,
	output logic tx_bad_crc,
	output logic rx_frame_ok,
	output logic rx_frame_err,
	output logic xrdy_abort,
	output logic tx_done,
	output logic tx_retry,
	output logic tx_fail,
	output logic [7:0] err_status,
	output logic shadow_err,
	output logic send_status
);
	typedef enum logic [3:0] {
		ST_IDLE, ST_RX_XRDY, ST_RX_DATA, ST_RX_ACK, ST_TX_XRDY,
		ST_TX_DATA, ST_TX_WAIT, ST_FLUSH
	} slte_state_t;
	typedef struct packed {
		slte_state_t st;
		slte_pkg::slte_prim_t tx_prim;
		logic [7:0] frm_err;
		logic [7:0] rx_words;
		logic [7:0] rx_type;
		logic [1:0] pio_gap;
		logic pio_armed;
		logic [15:0] tmo;
		logic [3:0] retries;
		logic [7:0] cur_type;
		logic data_nak;
		logic tx_bad_crc;
		logic rx_frame_ok;
		logic rx_frame_err;
		logic xrdy_abort;
		logic tx_done;
		logic tx_retry;
		logic tx_fail;
		logic shadow_err;
		logic send_status;
	} slte_reg_t;
	slte_reg_t s_q, s_d;
	logic [7:0] err_set;
	logic in_frame;
	logic retryable;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	assign in_frame = (s_q.st == ST_RX_DATA);
	always_comb begin
		case (s_q.cur_type)
			slte_pkg::FT_REG_H2D, slte_pkg::FT_REG_D2H,
			slte_pkg::FT_DMA_ACT, slte_pkg::FT_DMA_SETUP,
			slte_pkg::FT_PIO_SETUP, slte_pkg::FT_SDB: retryable = 1'b1;
			default: retryable = 1'b0;
		endcase
	end
	always_comb begin
		s_d = s_q;
		// Clear first so any set below wins
		if (err_clr) begin
			s_d.shadow_err = 1'b0;
		end
		err_set = '0;
		s_d.rx_frame_ok = 1'b0;
		s_d.rx_frame_err = 1'b0;
		s_d.xrdy_abort = 1'b0;
		s_d.tx_done = 1'b0;
		s_d.tx_retry = 1'b0;
		s_d.tx_fail = 1'b0;
		s_d.send_status = 1'b0;
		s_d.tx_bad_crc = 1'b0;
		case (s_q.st)
			ST_IDLE: begin
				s_d.tx_prim = slte_pkg::PRIM_SYNC;
				s_d.frm_err = '0;
				s_d.rx_words = '0;
				s_d.pio_armed = 1'b0;
				if (rx_prim == slte_pkg::PRIM_X_RDY) begin
					s_d.st = ST_RX_XRDY;
					s_d.tx_prim = slte_pkg::PRIM_R_RDY;
				end else if (tx_start) begin
					s_d.st = ST_TX_XRDY;
					s_d.cur_type = tx_type;
					s_d.retries = '0;
					s_d.tx_prim = slte_pkg::PRIM_X_RDY;
				end
			end
			ST_RX_XRDY: begin
				s_d.tx_prim = slte_pkg::PRIM_R_RDY;
				if (rx_prim == slte_pkg::PRIM_SOF) begin
					s_d.st = ST_RX_DATA;
					s_d.tx_prim = slte_pkg::PRIM_R_IP;
				end else if (rx_prim != slte_pkg::PRIM_X_RDY) begin
					s_d.xrdy_abort = 1'b1;
					err_set[slte_pkg::ERR_STATE] = 1'b1;
					s_d.st = ST_IDLE;
					s_d.tx_prim = slte_pkg::PRIM_SYNC;
				end
			end
			ST_RX_DATA: begin
				if (rx_code_err) begin
					s_d.frm_err[slte_pkg::ERR_CODING] = 1'b1;
				end
				if (rx_fifo_full && rx_prim == slte_pkg::PRIM_DATA) begin
					s_d.frm_err[slte_pkg::ERR_OVERFLOW] = 1'b1;
				end
				if (rx_prim == slte_pkg::PRIM_DATA) begin
					if (s_q.rx_words == 8'h00) begin
						s_d.rx_type = rx_type;
					end
					s_d.rx_words = s_q.rx_words + 8'h01;
				end
				if (pio_active && pio_cnt_zero && !s_q.pio_armed &&
					rx_prim == slte_pkg::PRIM_DATA) begin
					s_d.pio_armed = 1'b1;
					s_d.pio_gap = '0;
				end else if (s_q.pio_armed) begin
					s_d.pio_gap = s_q.pio_gap + 2'h1;
					if (s_q.pio_gap == slte_pkg::PIO_EOF_GAP - 2'h1 &&
						rx_prim != slte_pkg::PRIM_EOF) begin
						s_d.frm_err[slte_pkg::ERR_PIO_CNT] = 1'b1;
						s_d.pio_armed = 1'b0;
					end
				end
				if (rx_prim == slte_pkg::PRIM_EOF) begin
					s_d.st = ST_RX_ACK;
					s_d.tx_prim = slte_pkg::PRIM_R_IP;
					if (!rx_crc_ok) begin
						s_d.frm_err[slte_pkg::ERR_BAD_CRC] = 1'b1;
					end
					case (s_q.rx_type)
						slte_pkg::FT_REG_H2D, slte_pkg::FT_REG_D2H,
						slte_pkg::FT_DMA_ACT, slte_pkg::FT_DMA_SETUP,
						slte_pkg::FT_DATA, slte_pkg::FT_PIO_SETUP,
						slte_pkg::FT_SDB: ;
						default: s_d.frm_err[slte_pkg::ERR_BAD_TYPE] = 1'b1;
					endcase
					if (s_q.rx_type == slte_pkg::FT_REG_H2D &&
						s_q.rx_words != slte_pkg::REG_H2D_WORDS) begin
						s_d.frm_err[slte_pkg::ERR_BAD_LEN] = 1'b1;
					end
				end else if (rx_prim != slte_pkg::PRIM_DATA &&
					rx_prim != slte_pkg::PRIM_HOLD &&
					rx_prim != slte_pkg::PRIM_SYNC) begin
					s_d.frm_err[slte_pkg::ERR_STATE] = 1'b1;
					s_d.st = ST_RX_ACK;
				end else if (rx_prim == slte_pkg::PRIM_SYNC) begin
					err_set[slte_pkg::ERR_STATE] = 1'b1;
					s_d.st = ST_IDLE;
					s_d.tx_prim = slte_pkg::PRIM_SYNC;
				end
			end
			ST_RX_ACK: begin
				if (s_q.frm_err != 8'h00) begin
					s_d.tx_prim = slte_pkg::PRIM_R_ERR;
					s_d.rx_frame_err = 1'b1;
				end else begin
					s_d.tx_prim = slte_pkg::PRIM_R_OK;
					s_d.rx_frame_ok = 1'b1;
				end
				err_set = s_q.frm_err;
				if (s_q.frm_err != 8'h00) begin
					s_d.shadow_err = 1'b1;
					s_d.send_status = 1'b1;
				end
				s_d.st = ST_FLUSH;
			end
			ST_FLUSH: begin
				if (rx_prim == slte_pkg::PRIM_SYNC) begin
					s_d.st = ST_IDLE;
					s_d.tx_prim = slte_pkg::PRIM_SYNC;
				end
			end
			ST_TX_XRDY: begin
				s_d.tx_prim = slte_pkg::PRIM_X_RDY;
				if (rx_prim == slte_pkg::PRIM_R_RDY) begin
					s_d.st = ST_TX_DATA;
					s_d.tx_prim = slte_pkg::PRIM_SOF;
				end
			end
			ST_TX_DATA: begin
				s_d.tx_prim = slte_pkg::PRIM_DATA;
				if (tx_underrun) begin
					s_d.tx_bad_crc = 1'b1;
					s_d.tx_prim = slte_pkg::PRIM_EOF;
					s_d.st = ST_TX_WAIT;
					s_d.tmo = '0;
				end else if (tx_last) begin
					s_d.tx_prim = slte_pkg::PRIM_EOF;
					s_d.st = ST_TX_WAIT;
					s_d.tmo = '0;
				end
			end
			ST_TX_WAIT: begin
				s_d.tx_prim = slte_pkg::PRIM_WTRM;
				if (s_q.tmo != slte_pkg::ACK_TIMEOUT_CYC) begin
					s_d.tmo = s_q.tmo + 16'h0001;
				end
				if (rx_prim == slte_pkg::PRIM_R_OK) begin
					s_d.tx_done = 1'b1;
					s_d.st = ST_IDLE;
					s_d.tx_prim = slte_pkg::PRIM_SYNC;
				end else if (rx_prim == slte_pkg::PRIM_R_ERR ||
					rx_prim == slte_pkg::PRIM_SYNC) begin
					s_d.st = ST_IDLE;
					s_d.tx_prim = slte_pkg::PRIM_SYNC;
					if (retryable && s_q.retries < retry_limit) begin
						s_d.tx_retry = 1'b1;
						s_d.retries = s_q.retries + 4'h1;
						s_d.st = ST_TX_XRDY;
						s_d.tx_prim = slte_pkg::PRIM_X_RDY;
					end else begin
						s_d.tx_fail = 1'b1;
						err_set[slte_pkg::ERR_TX_FAIL] = 1'b1;
						if (s_q.cur_type == slte_pkg::FT_DATA) begin
							s_d.data_nak = 1'b1;
						end
					end
				end
			end
			default: begin
				s_d.st = ST_IDLE;
				s_d.tx_prim = slte_pkg::PRIM_SYNC;
			end
		endcase
		if (s_q.data_nak && tx_start && tx_type == slte_pkg::FT_REG_D2H &&
			s_q.st == ST_IDLE && rx_prim != slte_pkg::PRIM_X_RDY) begin
			s_d.shadow_err = 1'b1;
			s_d.data_nak = 1'b0;
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	slte_latch #(
		.W(8)
	) u_status (
		.clk(clk),
		.nrst(nrst),
		.clr(err_clr),
		.set(err_set),
		.q(err_status)
	);
	assign tx_prim = s_q.tx_prim;
	assign tx_bad_crc = s_q.tx_bad_crc;
	assign rx_frame_ok = s_q.rx_frame_ok;
	assign rx_frame_err = s_q.rx_frame_err;
	assign xrdy_abort = s_q.xrdy_abort;
	assign tx_done = s_q.tx_done;
	assign tx_retry = s_q.tx_retry;
	assign tx_fail = s_q.tx_fail;
	assign shadow_err = s_q.shadow_err;
	assign send_status = s_q.send_status;

	a_crc_nak: assert property (
		(s_q.st == ST_RX_DATA && rx_prim == slte_pkg::PRIM_EOF &&
		!rx_crc_ok) |=> ##1 (tx_prim == slte_pkg::PRIM_R_ERR && rx_frame_err))
		else $error("bad CRC not nacked");
	a_code_kept: assert property (
		(in_frame && rx_code_err) |=> s_q.frm_err[slte_pkg::ERR_CODING])
		else $error("coding error lost");
	a_xrdy_abort: assert property (
		(s_q.st == ST_RX_XRDY && rx_prim != slte_pkg::PRIM_SOF &&
		rx_prim != slte_pkg::PRIM_X_RDY) |=> (xrdy_abort && s_q.st == ST_IDLE))
		else $error("X_RDY abort missing");
	a_early_sof: assert property (
		(s_q.st == ST_IDLE && rx_prim == slte_pkg::PRIM_SOF && !tx_start)
		|=> (s_q.st == ST_IDLE && tx_prim == slte_pkg::PRIM_SYNC))
		else $error("early SOF accepted");
	a_tx_wait: assert property (
		(s_q.st == ST_TX_WAIT && rx_prim != slte_pkg::PRIM_SYNC &&
		rx_prim != slte_pkg::PRIM_R_OK && rx_prim != slte_pkg::PRIM_R_ERR)
		|=> s_q.st == ST_TX_WAIT)
		else $error("wait abandoned");
	a_no_data_rty: assert property (
		tx_retry |-> $past(s_q.cur_type) != slte_pkg::FT_DATA)
		else $error("data frame retried");
	a_retry_lim: assert property (
		tx_retry |-> s_q.retries <= $past(retry_limit))
		else $error("retry limit exceeded");
	a_underrun_crc: assert property (
		(s_q.st == ST_TX_DATA && tx_underrun)
		|=> (tx_bad_crc && tx_prim == slte_pkg::PRIM_EOF))
		else $error("underrun not corrupted");
	a_status_send: assert property (
		rx_frame_err |-> (send_status && shadow_err))
		else $error("error not reported");
	c_rx_ok: cover property (rx_frame_ok);
	c_rx_err: cover property (rx_frame_err);
	c_retry: cover property (tx_retry);
	c_fail: cover property (tx_fail);
endmodule // slte_err
`default_nettype wire

// *** slte_pkg.sv ***
`default_nettype none
package slte_pkg;
	// Primitive codes on the abstracted link symbol port
	typedef enum logic [3:0] {
		PRIM_DATA, PRIM_SYNC, PRIM_X_RDY, PRIM_R_RDY, PRIM_SOF, PRIM_EOF,
		PRIM_WTRM, PRIM_R_OK, PRIM_R_ERR, PRIM_R_IP, PRIM_HOLD, PRIM_OTHER
	} slte_prim_t;
	// Frame type codes
	localparam logic [7:0] FT_REG_H2D = 8'h27;
	localparam logic [7:0] FT_REG_D2H = 8'h34;
	localparam logic [7:0] FT_DMA_ACT = 8'h39;
	localparam logic [7:0] FT_DMA_SETUP = 8'h41;
	localparam logic [7:0] FT_DATA = 8'h46;
	localparam logic [7:0] FT_PIO_SETUP = 8'h5F;
	localparam logic [7:0] FT_SDB = 8'hA1;
	// Register host-to-device frame length in words, CRC included
	localparam logic [7:0] REG_H2D_WORDS = 8'h06;
	// Symbols from PIO count exhaustion to expected EOF
	localparam logic [1:0] PIO_EOF_GAP = 2'h2;
	// Transmit termination timeout
	localparam int ACK_TIMEOUT_NS = 10000;
	localparam int CLK_PERIOD_NS = 25;
	localparam logic [15:0] ACK_TIMEOUT_CYC =
		16'(ACK_TIMEOUT_NS / CLK_PERIOD_NS);
	localparam logic [3:0] RETRY_LIMIT_DEF = 4'h3;
	// Error status bit positions
	localparam int ERR_BAD_CRC = 0;
	localparam int ERR_CODING = 1;
	localparam int ERR_BAD_TYPE = 2;
	localparam int ERR_BAD_LEN = 3;
	localparam int ERR_OVERFLOW = 4;
	localparam int ERR_PIO_CNT = 5;
	localparam int ERR_STATE = 6;
	localparam int ERR_TX_FAIL = 7;
	localparam logic [7:0] ERR_RESET = 8'h00;
	// Shadow status error bit
	localparam int SH_ERR_BIT = 0;
endpackage
`default_nettype wire

// *** slte_latch.sv ***
`timescale 1ns/100ps
`default_nettype none
// Sticky flag: set wins over clear
module slte_latch #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic clr,
	input wire logic [W-1:0] set,
	output logic [W-1:0] q
);
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			q <= '0;
		end else begin
			q <= (clr ? '0 : q) | set;
		end
	end
endmodule // slte_latch
`default_nettype wire

// *** slte_peer.sv ***
`timescale 1ns/100ps
`default_nettype none
module slte_peer (
	input wire slte_pkg::slte_prim_t tx_prim,
	input wire slte_pkg::slte_prim_t tb_prim,
	input wire logic nak,
	output var slte_pkg::slte_prim_t rx_prim
);
	always_comb begin
		if (tx_prim == slte_pkg::PRIM_X_RDY) begin
			rx_prim = slte_pkg::PRIM_R_RDY;
		end else if (tx_prim == slte_pkg::PRIM_WTRM) begin
			rx_prim = nak ? slte_pkg::PRIM_R_ERR : slte_pkg::PRIM_R_OK;
		end else if (tx_prim == slte_pkg::PRIM_SOF ||
			tx_prim == slte_pkg::PRIM_DATA || tx_prim == slte_pkg::PRIM_EOF) begin
			// Receiving a frame: report reception in progress
			rx_prim = slte_pkg::PRIM_R_IP;
		end else begin
			rx_prim = tb_prim;
		end
	end
endmodule // slte_peer
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
	$display("wrong value at %0t: %h vs %h", $time, a, b); end end
module tb_top;
	typedef struct packed {
		logic [7:0] ty;
		logic [3:0] words;
		logic crc;
		logic code;
		logic full;
		logic pio;
		logic bad;
		logic [7:0] exp;
	} slte_row_t;
	logic clk = 0;
	logic nrst = 0;
	slte_pkg::slte_prim_t tb_prim = slte_pkg::PRIM_SYNC;
	slte_pkg::slte_prim_t rx_prim;
	slte_pkg::slte_prim_t tx_prim;
	logic rx_code_err = 0, rx_crc_ok = 0, rx_fifo_full = 0, nak = 0;
	logic pio_active = 0, pio_cnt_zero = 0, tx_start = 0, tx_last = 0;
	logic tx_underrun = 0, err_clr = 0;
	logic [7:0] rx_type = 0, tx_type = 0, err_status;
	logic [3:0] retry_limit = 0;
	logic tx_bad_crc, rx_frame_ok, rx_frame_err, xrdy_abort, tx_done;
	logic tx_retry, tx_fail, shadow_err, send_status;
	int errors = 0, tests_run = 0, n_ok, n_err, ack_bad, n_abort;
	int n_done, n_retry, n_fail, n_bad;
	slte_row_t rows [8] = '{
		'{slte_pkg::FT_REG_H2D, 4'h6, 1, 0, 0, 0, 0, 8'h00},
		'{slte_pkg::FT_REG_H2D, 4'h6, 0, 0, 0, 0, 0, 8'h01},
		'{slte_pkg::FT_REG_H2D, 4'h6, 1, 1, 0, 0, 0, 8'h02},
		'{8'h00, 4'h6, 1, 0, 0, 0, 0, 8'h04},
		'{slte_pkg::FT_REG_H2D, 4'h5, 1, 0, 0, 0, 0, 8'h08},
		'{slte_pkg::FT_DATA, 4'h6, 1, 0, 1, 0, 0, 8'h10},
		'{slte_pkg::FT_DATA, 4'h6, 1, 0, 0, 1, 0, 8'h20},
		'{slte_pkg::FT_REG_H2D, 4'h7, 1, 0, 0, 0, 1, 8'h40}};
	logic [7:0] rt [6] = '{slte_pkg::FT_REG_H2D, slte_pkg::FT_REG_D2H,
		slte_pkg::FT_DMA_ACT, slte_pkg::FT_DMA_SETUP,
		slte_pkg::FT_PIO_SETUP, slte_pkg::FT_SDB};

	slte_err DUT (.clk(clk), .nrst(nrst), .rx_prim(rx_prim),
		.rx_code_err(rx_code_err), .rx_crc_ok(rx_crc_ok), .rx_type(rx_type),
		.rx_fifo_full(rx_fifo_full), .pio_active(pio_active),
		.pio_cnt_zero(pio_cnt_zero), .tx_start(tx_start), .tx_type(tx_type),
		.tx_last(tx_last), .tx_underrun(tx_underrun),
		.retry_limit(retry_limit), .err_clr(err_clr), .tx_prim(tx_prim),
		.tx_bad_crc(tx_bad_crc), .rx_frame_ok(rx_frame_ok),
		.rx_frame_err(rx_frame_err), .xrdy_abort(xrdy_abort),
		.tx_done(tx_done), .tx_retry(tx_retry), .tx_fail(tx_fail),
		.err_status(err_status), .shadow_err(shadow_err),
		.send_status(send_status));
	slte_peer peer (.tx_prim(tx_prim), .tb_prim(tb_prim), .nak(nak),
		.rx_prim(rx_prim));

	initial begin
		forever #12.5 clk = ~clk;
	end

	// Pulse counters, sampled at each rising edge
	always @(posedge clk) begin
		if (rx_frame_ok) n_ok++;
		if (rx_frame_err) n_err++;
		if ((rx_frame_ok && tx_prim !== slte_pkg::PRIM_R_OK) ||
			(rx_frame_err && tx_prim !== slte_pkg::PRIM_R_ERR)) ack_bad++;
		if (xrdy_abort) n_abort++;
		if (tx_done) n_done++;
		if (tx_retry) n_retry++;
		if (tx_fail) n_fail++;
		if (tx_bad_crc && tx_prim === slte_pkg::PRIM_EOF) n_bad++;
	end

	task automatic give_verdict;
		$display("comparisons %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic send(input slte_pkg::slte_prim_t p, input int n);
		repeat (n) begin
			@(posedge clk);
			tb_prim <= p;
		end
	endtask

	task automatic rx_frame(input slte_row_t r);
		int k;
		n_ok = 0;
		n_err = 0;
		ack_bad = 0;
		@(posedge clk);
		err_clr <= 1'b1;
		tb_prim <= slte_pkg::PRIM_X_RDY;
		@(posedge clk);
		err_clr <= 1'b0;
		for (k = 0; k < 8 && tx_prim !== slte_pkg::PRIM_R_RDY; k++)
			@(posedge clk);
		tb_prim <= slte_pkg::PRIM_SOF;
		for (k = 0; k < r.words; k++) begin
			@(posedge clk);
			tb_prim <= (r.bad && k == 2) ? slte_pkg::PRIM_X_RDY :
				slte_pkg::PRIM_DATA;
			rx_type <= r.ty;
			rx_code_err <= r.code && k == 1;
			rx_fifo_full <= r.full;
			pio_active <= r.pio;
			pio_cnt_zero <= r.pio && k >= r.words - 3;
		end
		@(posedge clk);
		tb_prim <= slte_pkg::PRIM_EOF;
		rx_crc_ok <= r.crc;
		rx_fifo_full <= 1'b0;
		send(slte_pkg::PRIM_SYNC, 10);
		pio_active <= 1'b0;
		pio_cnt_zero <= 1'b0;
		`CHK(n_err, int'(r.exp != 0))
		`CHK(n_ok, int'(r.exp == 0))
		`CHK(ack_bad, 0)
		`CHK(err_status, r.exp)
		`CHK(tx_prim, slte_pkg::PRIM_SYNC)
	endtask

	task automatic tx_frame(input logic [7:0] ty, input logic nk,
		input logic un, input logic [3:0] lim, input int er, input int ef);
		int k;
		n_done = 0;
		n_retry = 0;
		n_fail = 0;
		n_bad = 0;
		@(posedge clk);
		nak <= nk;
		tx_underrun <= un;
		retry_limit <= lim;
		tx_type <= ty;
		tx_last <= 1'b1;
		tx_start <= 1'b1;
		@(posedge clk);
		tx_start <= 1'b0;
		for (k = 0; k < 400 && n_done + n_fail == 0; k++)
			@(posedge clk);
		repeat (8) @(posedge clk);
		`CHK(n_retry, er)
		`CHK(n_fail, ef)
		`CHK(n_done, 1 - ef)
		`CHK(n_bad, un ? er + 1 : 0)
	endtask

	initial begin
		#(25 * 30000);
		errors++;
		give_verdict();
	end

	initial begin
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		@(posedge clk);
		`CHK(tx_prim, slte_pkg::PRIM_SYNC)
		`CHK(err_status, slte_pkg::ERR_RESET)
		for (int i = 0; i < 8; i++) begin
			rx_frame(rows[i]);
			$display("rx row %0d done", i);
		end
		n_abort = 0;
		send(slte_pkg::PRIM_X_RDY, 2);
		send(slte_pkg::PRIM_SYNC, 6);
		`CHK(n_abort, 1)
		$display("x_rdy abort test done");
		n_ok = 0;
		n_err = 0;
		send(slte_pkg::PRIM_SOF, 1);
		for (int i = 0; i < 4; i++) begin
			send(slte_pkg::PRIM_DATA, 1);
			`CHK(tx_prim, slte_pkg::PRIM_SYNC)
		end
		send(slte_pkg::PRIM_EOF, 1);
		send(slte_pkg::PRIM_SYNC, 6);
		`CHK(n_ok + n_err, 0)
		$display("early sof test done");
		tx_frame(slte_pkg::FT_REG_H2D, 0, 0, 4'h3, 0, 0);
		tx_frame(slte_pkg::FT_DATA, 1, 0, 4'h3, 0, 1);
		`CHK(err_status[slte_pkg::ERR_TX_FAIL], 1'b1)
		@(posedge clk);
		err_clr <= 1'b1;
		@(posedge clk);
		err_clr <= 1'b0;
		@(posedge clk);
		`CHK(shadow_err, 1'b0)
		tx_frame(slte_pkg::FT_REG_D2H, 0, 0, 4'h3, 0, 0);
		`CHK(shadow_err, 1'b1)
		for (int i = 0; i < 6; i++) begin
			tx_frame(rt[i], 1, 0, 4'h1, 1, 1);
		end
		tx_frame(slte_pkg::FT_SDB, 1, 0, 4'h2, 2, 1);
		tx_frame(slte_pkg::FT_REG_D2H, 1, 1, 4'h0, 0, 1);
		$display("transmit tests done");
		give_verdict();
	end
endmodule // tb_top
`default_nettype wire
